// >>> inc/asrfb_pkg.sv
// package: register map, field positions and reset values of the receive flag block
package asrfb_pkg;
    // register byte addresses (word aligned)
    localparam logic [4:0] ADDR_STATUS_ONE = 5'h00;
    localparam logic [4:0] ADDR_STATUS_TWO = 5'h04;
    localparam logic [4:0] ADDR_DATA       = 5'h08;
    localparam logic [4:0] ADDR_BAUD       = 5'h0c;
    localparam logic [4:0] ADDR_CONTROL    = 5'h10;
    // status one bit positions
    localparam int BIT_RX_FULL  = 5;
    localparam int BIT_NOISE    = 2;
    localparam int BIT_FRAMING  = 1;
    localparam int BIT_PARITY   = 0;
    // status two bit positions
    localparam int BIT_BREAK    = 1;
    localparam int BIT_IN_PROG  = 0;
    // control three bit positions
    localparam int BIT_NINTH    = 7;
    localparam int BIT_NOISE_IE = 2;
    localparam int BIT_FRAME_IE = 1;
    localparam int BIT_PAR_IE   = 0;
    // baud register fields
    localparam int BIT_CLK_SEL  = 5;
    localparam int POS_PRESC    = 3;
    localparam int POS_RATE     = 0;
    // reset values
    localparam logic [7:0] BAUD_RESET    = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // oversampling factor of the baud generator
    localparam int OVERSAMPLE = 16;
    // bus answer for an unmapped address
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage : asrfb_pkg

// >>> rtl/asrfb_core.sv
// receive error flags, data buffer, baud generator and Avalon-MM register slave
//
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module asrfb_core
    import asrfb_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // receiver events, same clock
    input  wire logic        noise_event,
    input  wire logic        framing_event,
    input  wire logic        parity_event,
    input  wire logic        break_event,
    input  wire logic        rx_load,
    input  wire logic [8:0]  rx_word,
    input  wire logic        nine_bit_mode,
    input  wire logic        start_sample_low,
    input  wire logic        false_start,
    input  wire logic        idle_detect,
    // receive pin
    input  wire logic        rx_pin,
    // crystal reference clock, sampled as a pin
    input  wire logic        crystal_ref_clock,
    // transmit side
    output logic [7:0]       tx_data,
    output logic             tx_data_write,
    // status and baud outputs
    output logic             rx_full_flag,
    output logic             rx_in_progress_flag,
    output logic             error_irq,
    output logic             baud_tick
);

    logic [7:0] serial_data_buffer;
    logic [7:0] baud_setting;
    logic [7:0] control_three;
    logic       noise_flag;
    logic       framing_error_flag;
    logic       parity_error_flag;
    logic       break_flag;
    logic       rx_ninth_bit;
    logic       break_rearmed;
    logic [3:0] armed;
    logic       ack;
    logic       req_first;
    logic       rd_one;
    logic       rd_two;
    logic       rd_data;
    logic       wr_data;
    logic       wr_baud;
    logic       wr_control;
    logic [2:0] rx_sync;
    logic       line_high;
    logic [2:0] xtal_sync;
    logic       xtal_level;
    logic       xtal_edge;
    logic       baud_clock_select;
    logic [1:0] prescaler_select;
    logic [2:0] rate_divisor_select;
    logic [3:0] prescaler_divisor;
    logic [7:0] rate_divisor;
    logic [3:0] presc_cnt;
    logic [7:0] rate_cnt;
    logic       src_tick;
    logic       presc_tick;

    function automatic logic [3:0] presc_of(input logic [1:0] sel);
        case (sel)
            2'h0:    presc_of = 4'h1;
            2'h1:    presc_of = 4'h3;
            2'h2:    presc_of = 4'h4;
            default: presc_of = 4'hd;
        endcase
    endfunction : presc_of

    // bus decode: one wait cycle, answer on the second edge
    // read side effects on the first edge, with the values readdata captures
    assign req_first       = (avs_read | avs_write) & ~ack;
    assign avs_waitrequest = req_first;
    assign rd_one     = avs_read & req_first & (avs_address == ADDR_STATUS_ONE);
    assign rd_two     = avs_read & req_first & (avs_address == ADDR_STATUS_TWO);
    assign rd_data    = avs_read & req_first & (avs_address == ADDR_DATA);
    assign wr_data    = avs_write & ack & (avs_address == ADDR_DATA) & avs_byteenable[0];
    assign wr_baud    = avs_write & ack & (avs_address == ADDR_BAUD) & avs_byteenable[0];
    assign wr_control = avs_write & ack & (avs_address == ADDR_CONTROL) & avs_byteenable[0];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= req_first;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= UNMAPPED_DATA;
        end else if (avs_read & ~ack) begin
            case (avs_address)
                ADDR_STATUS_ONE[4:0]: avs_readdata <= {24'h0, 2'b00, rx_full_flag, 2'b00,
                                                       noise_flag, framing_error_flag,
                                                       parity_error_flag};
                ADDR_STATUS_TWO[4:0]: avs_readdata <= {24'h0, 6'h00, break_flag,
                                                       rx_in_progress_flag};
                ADDR_DATA[4:0]:       avs_readdata <= {24'h0, serial_data_buffer};
                ADDR_BAUD[4:0]:       avs_readdata <= {24'h0, baud_setting};
                ADDR_CONTROL[4:0]:    avs_readdata <= {24'h0, rx_ninth_bit, control_three[6:0]};
                default:              avs_readdata <= UNMAPPED_DATA;
            endcase
        end
    end

    // data buffer has no reset
    always_ff @(posedge clk) begin
        if (rx_load) begin
            serial_data_buffer <= rx_word[7:0];
        end
    end

    // transmit byte has no reset
    always_ff @(posedge clk) begin
        if (wr_data) begin
            tx_data <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_data_write <= 1'b0;
        end else begin
            tx_data_write <= wr_data;
        end
    end

    // ninth bit has no reset
    always_ff @(posedge clk) begin
        if (break_event & nine_bit_mode) begin
            rx_ninth_bit <= 1'b0;
        end else if (rx_load) begin
            rx_ninth_bit <= nine_bit_mode ? rx_word[8] : rx_word[7];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            baud_setting <= BAUD_RESET;
        end else if (wr_baud) begin
            baud_setting <= {2'b00, avs_writedata[5:0]};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            control_three <= CONTROL_RESET;
        end else if (wr_control) begin
            control_three <= {5'h00, avs_writedata[2:0]};
        end
    end

    // arming on status read, only for set flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            armed <= 4'h0;
        end else if (rd_data) begin
            armed <= 4'h0;
        end else begin
            if (rd_one) begin
                armed[2:0] <= {noise_flag, framing_error_flag, parity_error_flag};
            end
            if (rd_two) begin
                armed[3] <= break_flag;
            end
        end
    end

    // flags: set wins over clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            noise_flag <= 1'b0;
        end else if (noise_event) begin
            noise_flag <= 1'b1;
        end else if (rd_data & armed[2]) begin
            noise_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            framing_error_flag <= 1'b0;
        end else if (framing_event | break_event) begin
            framing_error_flag <= 1'b1;
        end else if (rd_data & armed[1]) begin
            framing_error_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            parity_error_flag <= 1'b0;
        end else if (parity_event) begin
            parity_error_flag <= 1'b1;
        end else if (rd_data & armed[0]) begin
            parity_error_flag <= 1'b0;
        end
    end

    // receiver-full flag, cleared by any data read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_full_flag <= 1'b0;
        end else if (rx_load | break_event) begin
            rx_full_flag <= 1'b1;
        end else if (rd_data) begin
            rx_full_flag <= 1'b0;
        end
    end

    // receive pin synchroniser
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_sync <= 3'b111;
        end else begin
            rx_sync <= {rx_sync[1:0], rx_pin};
        end
    end
    assign line_high = rx_sync[1] & rx_sync[2];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            break_flag    <= 1'b0;
            break_rearmed <= 1'b1;
        end else begin
            if (break_event & break_rearmed) begin
                break_flag    <= 1'b1;
                break_rearmed <= 1'b0;
            end else begin
                if (rd_data & armed[3]) begin
                    break_flag <= 1'b0;
                end
                if (line_high & ~break_flag) begin
                    break_rearmed <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_in_progress_flag <= 1'b0;
        end else if (start_sample_low) begin
            rx_in_progress_flag <= 1'b1;
        end else if (false_start | idle_detect) begin
            rx_in_progress_flag <= 1'b0;
        end
    end

    // break flag stays out of the interrupt; a break reaches it only through the framing flag
    assign error_irq = (noise_flag & control_three[BIT_NOISE_IE])
                     | (framing_error_flag & control_three[BIT_FRAME_IE])
                     | (parity_error_flag & control_three[BIT_PAR_IE]);

    // baud generator
    assign baud_clock_select   = baud_setting[BIT_CLK_SEL];
    assign prescaler_select    = baud_setting[POS_PRESC +: 2];
    assign rate_divisor_select = baud_setting[POS_RATE +: 3];
    assign prescaler_divisor   = presc_of(prescaler_select);
    assign rate_divisor        = 8'h01 << rate_divisor_select;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xtal_sync <= 3'b000;
        end else begin
            xtal_sync <= {xtal_sync[1:0], crystal_ref_clock};
        end
    end

    // level changes once second and third flops agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xtal_level <= 1'b0;
        end else if (xtal_sync[1] == xtal_sync[2]) begin
            xtal_level <= xtal_sync[2];
        end
    end
    assign xtal_edge = xtal_sync[1] & xtal_sync[2] & ~xtal_level;
    assign src_tick  = baud_clock_select ? 1'b1 : xtal_edge;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_cnt <= 4'h0;
        end else if (src_tick) begin
            presc_cnt <= (presc_cnt >= prescaler_divisor - 4'h1) ? 4'h0 : presc_cnt + 4'h1;
        end
    end
    assign presc_tick = src_tick & (presc_cnt >= prescaler_divisor - 4'h1);

    // tick at sixteen times the baud rate, shared by both directions
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_cnt  <= 8'h00;
            baud_tick <= 1'b0;
        end else begin
            baud_tick <= 1'b0;
            if (presc_tick) begin
                if (rate_cnt >= rate_divisor - 8'h01) begin
                    rate_cnt  <= 8'h00;
                    baud_tick <= 1'b1;
                end else begin
                    rate_cnt <= rate_cnt + 8'h01;
                end
            end
        end
    end

endmodule : asrfb_core
`default_nettype wire

// >>> test/asrfb_far_tx.sv
// partner: far transmitter holding the line low and marking break characters
`timescale 1ns/1ps
`default_nettype none
module asrfb_far_tx #(
    parameter int BREAK_LEN = 10
) (
    // clock and command
    input  wire logic clk,
    input  wire logic send_break,
    // line side
    output logic      rx_pin,
    output logic      break_event
);
    int cnt = 0;
    initial begin
        rx_pin = 1'b1;
        break_event = 1'b0;
    end
    // held break repeats with no ones between
    always @(posedge clk) begin
        rx_pin <= !send_break;
        break_event <= send_break && cnt == BREAK_LEN - 1;
        cnt <= (send_break && cnt < BREAK_LEN - 1) ? cnt + 1 : 0;
    end
endmodule : asrfb_far_tx
`default_nettype wire

// >>> test/asrfb_sva.sv
// checker: bus answer, transmit write and status flag timing
`timescale 1ns/1ps
`default_nettype none
module asrfb_sva
    import asrfb_pkg::*;
(
    // bus
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // events and outputs
    input wire logic        break_event,
    input wire logic        start_sample_low,
    input wire logic        false_start,
    input wire logic        idle_detect,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_data_write,
    input wire logic        rx_full_flag,
    input wire logic        rx_in_progress_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence data_write;
        avs_write && !avs_waitrequest && avs_address == ADDR_DATA && avs_byteenable[0];
    endsequence
    sequence tx_strobe;
        tx_data_write ##1 !tx_data_write;
    endsequence
    a_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_tx_strobe: assert property (data_write |=> tx_strobe)
        else $error("no transmit strobe");
    a_tx_value: assert property (tx_data_write |-> tx_data == $past(avs_writedata[7:0]))
        else $error("wrong transmit byte");
    a_brk_full: assert property (break_event |=> rx_full_flag)
        else $error("break left full flag clear");
    a_prog_set: assert property (start_sample_low |=> rx_in_progress_flag)
        else $error("progress flag not set");
    a_prog_clr: assert property ((false_start || idle_detect) && !start_sample_low
        |=> !rx_in_progress_flag)
        else $error("progress flag not cleared");
    a_prog_cause: assert property ($rose(rx_in_progress_flag) |-> $past(start_sample_low))
        else $error("progress flag set unprompted");
    a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered");
endmodule : asrfb_sva
bind asrfb_core asrfb_sva asrfb_sva_inst (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .break_event,
    .start_sample_low,
    .false_start, .idle_detect, .tx_data, .tx_data_write, .rx_full_flag, .rx_in_progress_flag);
`default_nettype wire

// >>> test/async_serial_rx_flags_and_baud_test.sv
// testbench: flags, data buffer and baud generator against a bench model
`timescale 1ns/1ps
`default_nettype none
module async_serial_rx_flags_and_baud_test;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic        nine = 1'b1;
    logic        brk = 1'b0;
    logic        xtal = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [31:0] wd = 32'h0;
    logic [31:0] q, rdat;
    logic [8:0]  word = 9'h000;
    logic [6:0]  ev = 7'h00;
    logic [7:0]  txd;
    logic        wq, txw, full, prog, irq, tick, rxp, bev;
    int bad_count = 0, samples_checked = 0, seed = 28348, cyc = 0;
    int s1 = 0, s2 = 0, a1 = 0, a2 = 0, ctl = 0, rxb = 0, nb = 0, lok = 1, i, n, p, r;
    asrfb_core asrfb_core_inst (.clk, .rst_n, .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wq),
        .noise_event(ev[0]), .framing_event(ev[1]), .parity_event(ev[2]), .break_event(bev),
        .rx_load(ev[3]), .rx_word(word), .nine_bit_mode(nine), .start_sample_low(ev[4]),
        .false_start(ev[5]), .idle_detect(ev[6]), .rx_pin(rxp), .crystal_ref_clock(xtal),
        .tx_data(txd), .tx_data_write(txw), .rx_full_flag(full), .rx_in_progress_flag(prog),
        .error_irq(irq), .baud_tick(tick));
    asrfb_far_tx #(.BREAK_LEN(24)) asrfb_far_tx_inst (.clk, .send_break(brk), .rx_pin(rxp),
        .break_event(bev));
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        // crystal reference, six clock periods
        if (cyc % 3 == 2)
            xtal <= ~xtal;
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end
    // model of break detection
    always @(posedge clk) begin
        if (bev === 1'b1) begin
            s1 |= 34;
            s2 |= lok << 1;
            nb = nine ? 0 : nb;
            lok = 0;
        end else if (rxp === 1'b1 && !s2[1])
            lok = 1;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        do begin
            @(posedge clk);
        end while (wq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task rdchk(input logic [4:0] a, input int e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rdchk
    task outs();
        @(negedge clk);
        chk(irq, |(s1 & ctl & 7));
        chk(full, s1[5]);
        chk(prog, s2[0]);
    endtask : outs
    task st1();
        rdchk(5'h00, s1);
        a1 = s1 & 7;
    endtask : st1
    task st2();
        rdchk(5'h04, s2);
        a2 = s2 & 2;
    endtask : st2
    task dat();
        rdchk(5'h08, rxb);
        s1 &= ~(a1 | 32);
        s2 &= ~a2;
        a1 = 0;
        a2 = 0;
        outs();
    endtask : dat
    task pulse(input int k);
        @(posedge clk);
        ev[k] <= 1'b1;
        @(posedge clk);
        ev[k] <= 1'b0;
        if (k < 3)
            s1 |= 4 >> k;
        if (k == 3) begin
            s1 |= 32;
            rxb = word[7:0];
            nb = nine ? word[8] : word[7];
        end
        if (k == 4)
            s2 |= 1;
        if (k > 4)
            s2 &= ~1;
        outs();
    endtask : pulse
    task end_sim();
        $display("compared %0d mismatched %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(5'h0c, 0);
        st1();
        st2();
        for (i = 0; i < 4; i++) begin
            nine <= i[0];
            word <= 9'($random(seed));
            pulse(3);
            rdchk(5'h10, ctl | nb << 7);
            st1();
            dat();
        end
        for (i = 0; i < 6; i++) begin
            ctl = $random(seed) & 7;
            bus(1'b1, 5'h10, ctl);
            pulse(i % 3);
            st1();
            pulse((i + 1) % 3);
            dat();
            st1();
            dat();
        end
        bus(1'b1, 5'h08, $random(seed));
        @(negedge clk);
        chk(txd, wd[7:0]);
        chk(txw, 1'b1);
        bus(1'b1, 5'h14, 32'hff);
        rdchk(5'h14, 0);
        for (i = 5; i < 7; i++) begin
            pulse(4);
            st2();
            pulse(i);
            st2();
        end
        nine <= 1'b1;
        brk <= 1'b1;
        for (i = 0; i < 3; i++) begin
            @(posedge bev);
            @(posedge clk);
            outs();
            st2();
            rdchk(5'h10, ctl | nb << 7);
            st1();
            dat();
            if (i == 1) begin
                brk <= 1'b0;
                repeat (12) @(posedge clk);
                brk <= 1'b1;
            end
        end
        brk <= 1'b0;
        // bus source first, then crystal source
        for (i = 0; i < 8; i++) begin
            p = i & 3;
            r = ($random(seed) & (i < 4 ? 3 : 1)) + 1;
            n = (i < 4 ? 32 : 0) | p << 3 | r;
            bus(1'b1, 5'h0c, n);
            rdchk(5'h0c, n);
            repeat (2) @(posedge tick);
            @(negedge clk);
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (tick !== 1'b1 && n < 1000);
            chk(n, ((i < 4 ? 1 : 6) * (p == 3 ? 13 : (p ? p + 2 : 1))) << r);
        end
        // mid-run reset clears flags and baud, keeps data
        pulse(0);
        pulse(4);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        s1 = 0;
        s2 = 0;
        ctl = 0;
        lok = 1;
        outs();
        st1();
        st2();
        rdchk(5'h0c, 0);
        rdchk(5'h10, nb << 7);
        rdchk(5'h08, rxb);
        end_sim();
    end
endmodule : async_serial_rx_flags_and_baud_test
`default_nettype wire
